//--- pkg/pio_pkg.sv
// constants, modes and routes for the programmable pin I/O logic
//
// Overview of operation
// RULE_01: input mode enables only receive; pad reaches core directly or via input register.
// RULE_02: registered receive samples the pad on the chosen capture clock edge.
// RULE_03: bypass input feeds the alternate function and never uses the input register.
// RULE_04: bypass input routes to global clock, global control or synth reference.
// RULE_05: output mode enables only transmit; core data drives pad directly or registered.
// RULE_06: registered transmit updates on the chosen launch clock edge.
// RULE_07: output register value may be inverted in output and bidirectional modes.
// RULE_08: bidirectional mode enables receive, transmit and output-enable paths together.
// RULE_09: capture clock drives input register; launch clock drives output and enable registers.
// RULE_10: bidirectional receive and transmit registering are chosen independently.
// RULE_11: clock-output mode drives a core tree clock onto the pad, bypassing core data.
// RULE_12: core output enable decides pad drive, optionally through the enable register. The code applies it in bidirectional mode only.
// RULE_13: the output-enable register switches the pad driver when the pin outputs. The code uses it in bidirectional mode only; output mode always drives.
// RULE_14: input register captures the pad value before it goes to the core.
// RULE_15: received pad value goes to the core on the receive data output.
// RULE_16: core transmit data is accepted and delivered to the pad.
// RULE_17: during configuration every pin is held in weak pull-up.
// RULE_18: unused pins in user mode tri-state with weak pull-up, optionally pull-down.
// RULE_19: weak pull-up pins in user mode show no glitch on the pad.
// RULE_20: with enable low the driver is off; bidirectional receive still sees the pad.
package pio_pkg;

   // ****************************************
   // pin modes
   // ****************************************
   typedef enum logic [1:0] {
      PIO_MODE_INPUT = 2'b00,
      PIO_MODE_OUTPUT = 2'b01,
      PIO_MODE_BIDIR = 2'b10,
      PIO_MODE_CLKOUT = 2'b11
   } pio_mode_t;

   // ****************************************
   // bypass routes
   // ****************************************
   typedef enum logic [1:0] {
      PIO_ROUTE_NONE = 2'b00,
      PIO_ROUTE_CLOCK = 2'b01,
      PIO_ROUTE_CONTROL = 2'b10,
      PIO_ROUTE_SYNTH = 2'b11
   } pio_route_t;

   // ****************************************
   // values after reset
   // ****************************************
   localparam logic PIO_RST_OUT = 1'h0;
   localparam logic PIO_RST_OE = 1'h0;
   localparam logic PIO_RST_PULLUP = 1'h1;
   localparam logic PIO_RST_PULLDOWN = 1'h0;
   localparam logic PIO_RST_DATA = 1'h0;
   localparam logic PIO_RST_SYNC = 1'h0;

endpackage

//--- rtl/pio_sync3.sv
// three-stage input synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps

module pio_sync3 (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic asyncIn,
   output logic level,
   output logic rise,
   output logic fall
);

   logic stage1;
   logic stage2;
   logic stage3;
   logic agree;

   // ****************************************
   // synchroniser chain
   // ****************************************
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         stage1 <= pio_pkg::PIO_RST_SYNC;
         stage2 <= pio_pkg::PIO_RST_SYNC;
         stage3 <= pio_pkg::PIO_RST_SYNC;
      end else begin
         stage1 <= asyncIn;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   assign agree = (stage2 == stage3);

   // ****************************************
   // filtered level and edges
   // ****************************************
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         level <= pio_pkg::PIO_RST_SYNC;
         rise <= pio_pkg::PIO_RST_SYNC;
         fall <= pio_pkg::PIO_RST_SYNC;
      end else begin
         if (agree) begin
            level <= stage3;
         end
         rise <= agree && stage3 && !level;
         fall <= agree && !stage3 && level;
      end
   end

endmodule // pio_sync3

//--- rtl/pio_pin_logic.sv
// I/O logic for one general-purpose pin
`timescale 1ns/1ps

module pio_pin_logic (
   input wire logic core_clk,
   input wire logic reset_n,
   // configuration
   input wire logic configDone,
   input wire logic pinUsed,
   input wire logic [1:0] pinMode,
   input wire logic rxRegEn,
   input wire logic rxFallEdge,
   input wire logic txRegEn,
   input wire logic txFallEdge,
   input wire logic txInvert,
   input wire logic oeRegEn,
   input wire logic oeFallEdge,
   input wire logic pullDownSel,
   input wire logic [1:0] bypassRoute,
   // core side
   input wire logic captureClock,
   input wire logic launchClock,
   input wire logic treeClock,
   input wire logic txData,
   input wire logic txOe,
   output logic rxData,
   output logic globalClockNet,
   output logic globalControlNet,
   output logic synthReferenceInput,
   // pad side
   input wire logic padIn,
   output logic padOut,
   output logic padOe,
   output logic padPullUp,
   output logic padPullDown
);

   logic padLevel;
   logic capRise;
   logic capFall;
   logic lchRise;
   logic lchFall;
   logic treeLevel;
   logic captureEdge;
   logic txEdge;
   logic oeEdge;
   logic rxReg;
   logic txReg;
   logic oeReg;
   logic userActive;
   logic rxPathOn;
   logic txPathOn;
   logic oePathOn;
   logic clkPathOn;
   logic bypassActive;
   logic txValue;
   logic oeValue;
   logic next_padOut;
   logic next_padOe;
   logic next_padPullUp;
   logic next_padPullDown;
   logic next_rxData;
   pio_pkg::pio_mode_t mode;
   pio_pkg::pio_route_t route;

   // ****************************************
   // synchronisers for outside inputs
   // ****************************************
   pio_sync3 padSync (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .asyncIn(padIn),
      .level(padLevel),
      .rise(),
      .fall()
   );

   pio_sync3 captureSync (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .asyncIn(captureClock),
      .level(),
      .rise(capRise),
      .fall(capFall)
   );

   pio_sync3 launchSync (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .asyncIn(launchClock),
      .level(),
      .rise(lchRise),
      .fall(lchFall)
   );

   pio_sync3 treeSync (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .asyncIn(treeClock),
      .level(treeLevel),
      .rise(),
      .fall()
   );

   // ****************************************
   // path enables per mode
   // ****************************************
   always_comb begin
      mode = pio_pkg::pio_mode_t'(pinMode);
      route = pio_pkg::pio_route_t'(bypassRoute);
      userActive = configDone && pinUsed;
      rxPathOn = userActive && (mode == pio_pkg::PIO_MODE_INPUT ||
         mode == pio_pkg::PIO_MODE_BIDIR); // [RULE_01] [RULE_08]
      txPathOn = userActive && (mode == pio_pkg::PIO_MODE_OUTPUT ||
         mode == pio_pkg::PIO_MODE_BIDIR); // [RULE_05] [RULE_08]
      oePathOn = userActive && (mode == pio_pkg::PIO_MODE_BIDIR); // [RULE_08]
      clkPathOn = userActive && (mode == pio_pkg::PIO_MODE_CLKOUT); // [RULE_11]
      bypassActive = userActive && (mode == pio_pkg::PIO_MODE_INPUT) && !rxRegEn; // [RULE_03]
   end

   // ****************************************
   // edge selection
   // ****************************************
   always_comb begin
      captureEdge = rxFallEdge ? capFall : capRise; // [RULE_02]
      txEdge = txFallEdge ? lchFall : lchRise; // [RULE_06] [RULE_09]
      oeEdge = oeFallEdge ? lchFall : lchRise; // [RULE_09]
   end

   // ****************************************
   // input register
   // ****************************************
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rxReg <= pio_pkg::PIO_RST_DATA;
      end else if (captureEdge) begin
         rxReg <= padLevel; // [RULE_02] [RULE_14]
      end
   end

   // ****************************************
   // output register
   // ****************************************
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         txReg <= pio_pkg::PIO_RST_OUT;
      end else if (txEdge) begin
         txReg <= txData; // [RULE_06] [RULE_16]
      end
   end

   // ****************************************
   // output-enable register
   // ****************************************
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         oeReg <= pio_pkg::PIO_RST_OE;
      end else if (oeEdge) begin
         oeReg <= txOe; // [RULE_09] [RULE_13]
      end
   end

   // ****************************************
   // pad drive and pulls
   // ****************************************
   always_comb begin
      txValue = txRegEn ? (txInvert ? !txReg : txReg) : txData; // [RULE_07] [RULE_10] [RULE_16]
      oeValue = oeRegEn ? oeReg : txOe; // [RULE_12] [RULE_13]
      next_padOut = 1'h0;
      next_padOe = 1'h0;
      if (clkPathOn) begin
         next_padOut = treeLevel; // [RULE_11]
         next_padOe = 1'h1;
      end else if (oePathOn) begin
         next_padOut = txValue;
         next_padOe = oeValue; // [RULE_12] [RULE_20]
      end else if (txPathOn) begin
         next_padOut = txValue; // [RULE_05]
         next_padOe = 1'h1;
      end
      next_padPullUp = !configDone || (!pinUsed && !pullDownSel); // [RULE_17] [RULE_18] [RULE_19]
      next_padPullDown = configDone && !pinUsed && pullDownSel; // [RULE_18]
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         padOut <= pio_pkg::PIO_RST_OUT;
         padOe <= pio_pkg::PIO_RST_OE;
      end else begin
         padOut <= next_padOut;
         padOe <= next_padOe;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         padPullUp <= pio_pkg::PIO_RST_PULLUP;
         padPullDown <= pio_pkg::PIO_RST_PULLDOWN;
      end else begin
         padPullUp <= next_padPullUp; // [RULE_19]
         padPullDown <= next_padPullDown;
      end
   end

   // ****************************************
   // receive data to core
   // ****************************************
   always_comb begin
      next_rxData = 1'h0;
      if (rxPathOn) begin
         next_rxData = rxRegEn ? rxReg : padLevel; // [RULE_01] [RULE_10] [RULE_20]
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rxData <= pio_pkg::PIO_RST_DATA;
      end else begin
         rxData <= next_rxData; // [RULE_15]
      end
   end

   // ****************************************
   // bypass input routing
   // ****************************************
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         globalClockNet <= pio_pkg::PIO_RST_DATA;
         globalControlNet <= pio_pkg::PIO_RST_DATA;
         synthReferenceInput <= pio_pkg::PIO_RST_DATA;
      end else begin
         globalClockNet <= bypassActive && (route == pio_pkg::PIO_ROUTE_CLOCK) &&
            padLevel; // [RULE_03] [RULE_04]
         globalControlNet <= bypassActive && (route == pio_pkg::PIO_ROUTE_CONTROL) &&
            padLevel; // [RULE_04]
         synthReferenceInput <= bypassActive && (route == pio_pkg::PIO_ROUTE_SYNTH) &&
            padLevel; // [RULE_04]
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   a_config_pullup: assert property (@(posedge core_clk) disable iff (!reset_n) // [RULE_17]
      !configDone |=> padPullUp && !padPullDown && !padOe)
      else $error("pin not in weak pull-up during configuration");

   a_unused_pull: assert property (@(posedge core_clk) disable iff (!reset_n) // [RULE_18]
      configDone && !pinUsed |=> !padOe && (padPullDown == $past(pullDownSel)) &&
      (padPullUp == !$past(pullDownSel)))
      else $error("unused pin not tri-stated with selected pull");

   a_pullup_steady: assert property (@(posedge core_clk) disable iff (!reset_n) // [RULE_19]
      !pinUsed && !pullDownSel && $past(!pinUsed && !pullDownSel) |=> $stable(padPullUp))
      else $error("weak pull-up glitched");

   a_input_nodrive: assert property (@(posedge core_clk) disable iff (!reset_n) // [RULE_01]
      userActive && mode == pio_pkg::PIO_MODE_INPUT |=> !padOe)
      else $error("input mode drives the pad");

   a_rx_direct: assert property (@(posedge core_clk) disable iff (!reset_n) // [RULE_15]
      rxPathOn && !rxRegEn |=> rxData == $past(padLevel))
      else $error("unregistered receive data wrong");

   a_rx_reg_edge: assert property (@(posedge core_clk) disable iff (!reset_n) // [RULE_02]
      !captureEdge |=> $stable(rxReg))
      else $error("input register changed without capture edge");

   a_rx_reg_path: assert property (@(posedge core_clk) disable iff (!reset_n) // [RULE_14]
      captureEdge ##1 (rxPathOn && rxRegEn) |=> rxData == $past(padLevel, 2))
      else $error("registered receive data wrong");

   a_tx_direct: assert property (@(posedge core_clk) disable iff (!reset_n) // [RULE_05]
      userActive && mode == pio_pkg::PIO_MODE_OUTPUT && !txRegEn |=>
      padOe && padOut == $past(txData))
      else $error("direct transmit path wrong");

   a_tx_reg_edge: assert property (@(posedge core_clk) disable iff (!reset_n) // [RULE_06]
      !txEdge |=> $stable(txReg))
      else $error("output register changed without launch edge");

   a_tx_invert: assert property (@(posedge core_clk) disable iff (!reset_n) // [RULE_07]
      txPathOn && txRegEn && txInvert |=> padOut == !$past(txReg))
      else $error("inverted output wrong");

   a_bidir_oe: assert property (@(posedge core_clk) disable iff (!reset_n) // [RULE_12]
      oePathOn |=> padOe == ($past(oeRegEn) ? $past(oeReg) : $past(txOe)))
      else $error("bidirectional enable wrong");

   a_clkout_path: assert property (@(posedge core_clk) disable iff (!reset_n) // [RULE_11]
      clkPathOn |=> padOe && padOut == $past(treeLevel))
      else $error("clock output path wrong");

   a_bypass_route: assert property (@(posedge core_clk) disable iff (!reset_n) // [RULE_03]
      !bypassActive |=> !globalClockNet && !globalControlNet && !synthReferenceInput)
      else $error("bypass active outside unregistered input mode");

   a_route_clock: assert property (@(posedge core_clk) disable iff (!reset_n) // [RULE_04]
      bypassActive && route == pio_pkg::PIO_ROUTE_CLOCK |=>
      globalClockNet == $past(padLevel) && !globalControlNet && !synthReferenceInput)
      else $error("bypass not carried on global clock net alone");

   a_route_control: assert property (@(posedge core_clk) disable iff (!reset_n) // [RULE_04]
      bypassActive && route == pio_pkg::PIO_ROUTE_CONTROL |=>
      globalControlNet == $past(padLevel) && !globalClockNet && !synthReferenceInput)
      else $error("bypass not carried on global control net alone");

   a_route_synth: assert property (@(posedge core_clk) disable iff (!reset_n) // [RULE_04]
      bypassActive && route == pio_pkg::PIO_ROUTE_SYNTH |=>
      synthReferenceInput == $past(padLevel) && !globalClockNet && !globalControlNet)
      else $error("bypass not carried on synth reference alone");

endmodule // pio_pin_logic

//--- verification/pio_pad_board.sv
// board-side model of the signal wired to the pin pad
`timescale 1ns/1ps

module pio_pad_board (
   input wire logic extOe,
   input wire logic extVal,
   input wire logic padOut,
   input wire logic padOe,
   input wire logic padPullUp,
   input wire logic padPullDown,
   output logic padIn
);
   // ****
   // pad resolution
   // ****
   logic last = 1'h0;
   always @* begin
      if (padOe & extOe) padIn = (padOut === extVal) ? padOut : 1'hx;
      else if (padOe) padIn = padOut;
      else if (extOe) padIn = extVal;
      else if (padPullUp) padIn = 1'h1;
      else if (padPullDown) padIn = 1'h0;
      else padIn = ~last;
   end
   // released line without pull shows the inverse of its last level
   always @(padOut or extVal or padOe or extOe) begin
      if (padOe ^ extOe) last = padOe ? padOut : extVal;
   end
endmodule // pio_pad_board

//--- verification/programmable_pin_io_logic_tb.sv
// self-checking bench for the programmable pin I/O logic
`timescale 1ns/1ps

module programmable_pin_io_logic_tb;
   logic core_clk, reset_n, configDone, pinUsed, rxRegEn, rxFallEdge, txRegEn, txFallEdge;
   logic txInvert, oeRegEn, oeFallEdge, pullDownSel, captureClock, launchClock, treeClock;
   logic txData, txOe, extOe, extVal, inReg, txReg, oeReg, watchPull;
   logic rxData, globalClockNet, globalControlNet, synthReferenceInput;
   logic padIn, padOut, padOe, padPullUp, padPullDown;
   logic [1:0] pinMode, bypassRoute;
   int mismatches, checks, seed, glitches, i, r;

   pio_pin_logic dut (.core_clk(core_clk), .reset_n(reset_n), .configDone(configDone),
      .pinUsed(pinUsed), .pinMode(pinMode), .rxRegEn(rxRegEn), .rxFallEdge(rxFallEdge),
      .txRegEn(txRegEn), .txFallEdge(txFallEdge), .txInvert(txInvert), .oeRegEn(oeRegEn),
      .oeFallEdge(oeFallEdge), .pullDownSel(pullDownSel), .bypassRoute(bypassRoute),
      .captureClock(captureClock), .launchClock(launchClock), .treeClock(treeClock),
      .txData(txData), .txOe(txOe), .rxData(rxData), .globalClockNet(globalClockNet),
      .globalControlNet(globalControlNet), .synthReferenceInput(synthReferenceInput),
      .padIn(padIn), .padOut(padOut), .padOe(padOe), .padPullUp(padPullUp),
      .padPullDown(padPullDown));

   pio_pad_board board (.extOe(extOe), .extVal(extVal), .padOut(padOut), .padOe(padOe),
      .padPullUp(padPullUp), .padPullDown(padPullDown), .padIn(padIn));

   initial begin
      core_clk = 1'h0;
      forever #20 core_clk = ~core_clk;
   end

   always @(negedge padPullUp) begin
      if (watchPull) glitches++;
   end

   // ****
   // reference model
   // ****
   function automatic logic exp_oe();
      logic act;
      act = pinUsed & configDone;
      if (pinMode == pio_pkg::PIO_MODE_BIDIR) return act & (oeRegEn ? oeReg : txOe);
      return act & pinMode[0];
   endfunction

   function automatic logic exp_out();
      if (pinMode == pio_pkg::PIO_MODE_CLKOUT) return treeClock;
      return txRegEn ? txReg ^ txInvert : txData;
   endfunction

   function automatic logic exp_pad();
      return extOe ? extVal : exp_out();
   endfunction

   task automatic cmp(input string name, input logic seen, input logic want);
      checks++;
      if (seen !== want) begin
         mismatches++;
         $display("wrong value %s expected %b seen %b", name, want, seen);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic check_all();
      logic act, pad, rxOn, byp;
      pio_pkg::pio_route_t rt;
      if (pinMode == pio_pkg::PIO_MODE_BIDIR) extOe = ~exp_oe();
      repeat (16) @(negedge core_clk);
      act = pinUsed & configDone;
      pad = exp_pad();
      rxOn = act & ~pinMode[0];
      byp = act & (pinMode == pio_pkg::PIO_MODE_INPUT) & ~rxRegEn & pad;
      rt = pio_pkg::pio_route_t'(bypassRoute);
      cmp("padOe", padOe, exp_oe());
      if (exp_oe()) cmp("padOut", padOut, exp_out());
      cmp("rxData", rxData, rxOn & (rxRegEn ? inReg : pad));
      cmp("clockNet", globalClockNet, byp & (rt == pio_pkg::PIO_ROUTE_CLOCK));
      cmp("controlNet", globalControlNet, byp & (rt == pio_pkg::PIO_ROUTE_CONTROL));
      cmp("synthRef", synthReferenceInput, byp & (rt == pio_pkg::PIO_ROUTE_SYNTH));
      cmp("padPullUp", padPullUp, ~configDone | (~pinUsed & ~pullDownSel));
      cmp("padPullDown", padPullDown, configDone & ~pinUsed & pullDownSel);
   endtask

   task automatic cap_edge();
      captureClock = ~captureClock;
      if (captureClock != rxFallEdge) inReg = exp_pad();
      check_all();
   endtask

   task automatic launch_edge();
      launchClock = ~launchClock;
      if (launchClock != txFallEdge) txReg = txData;
      if (launchClock != oeFallEdge) oeReg = txOe;
      check_all();
   endtask

   initial begin
      repeat (60000) @(posedge core_clk);
      mismatches++;
      finish_test();
   end

   // ****
   // scenarios
   // ****
   initial begin
      seed = 32'h8d90;
      {configDone, pinUsed, rxRegEn, rxFallEdge, txRegEn, txFallEdge, txInvert} = 7'h00;
      {oeRegEn, oeFallEdge, pullDownSel, captureClock, launchClock, treeClock} = 6'h00;
      {txData, txOe, extVal, inReg, txReg, oeReg, watchPull} = 7'h00;
      extOe = 1'h1;
      pinMode = 2'h0;
      bypassRoute = 2'h0;
      reset_n = 1'h0;
      repeat (4) @(negedge core_clk);
      cmp("padPullUp", padPullUp, 1'h1);
      cmp("padOe", padOe, 1'h0);
      repeat (4) @(negedge core_clk);
      watchPull = 1'h1;
      reset_n = 1'h1;
      pinMode = pio_pkg::PIO_MODE_OUTPUT;
      check_all();
      configDone = 1'h1;
      check_all();
      cmp("pullGlitches", glitches == 0, 1'h1);
      watchPull = 1'h0;
      pullDownSel = 1'h1;
      check_all();
      pullDownSel = 1'h0;
      pinMode = pio_pkg::PIO_MODE_INPUT;
      pinUsed = 1'h1;
      for (i = 0; i < 8; i++) begin
         r = $random(seed);
         bypassRoute = i[1:0];
         extVal = r[0];
         check_all();
      end
      rxRegEn = 1'h1;
      for (i = 0; i < 8; i++) begin
         r = $random(seed);
         rxFallEdge = i[2];
         extVal = r[0];
         check_all();
         cap_edge();
      end
      rxRegEn = 1'h0;
      extOe = 1'h0;
      pinMode = pio_pkg::PIO_MODE_OUTPUT;
      for (i = 0; i < 6; i++) begin
         r = $random(seed);
         {txData, txOe} = r[1:0];
         check_all();
      end
      txRegEn = 1'h1;
      oeRegEn = 1'h1;
      for (i = 0; i < 8; i++) begin
         r = $random(seed);
         {txData, txOe} = r[1:0];
         txFallEdge = i[1];
         txInvert = i[2];
         launch_edge();
      end
      {txRegEn, oeRegEn, txOe} = 3'h0;
      pinMode = pio_pkg::PIO_MODE_BIDIR;
      check_all();
      txOe = 1'h1;
      check_all();
      txRegEn = 1'h1;
      oeRegEn = 1'h1;
      for (i = 0; i < 16; i++) begin
         r = $random(seed);
         {txData, txOe, extVal} = r[2:0];
         {rxFallEdge, rxRegEn, txFallEdge, oeFallEdge} = i[3:0];
         txInvert = r[3];
         launch_edge();
         if (rxRegEn) cap_edge();
      end
      extOe = 1'h0;
      pinMode = pio_pkg::PIO_MODE_CLKOUT;
      for (i = 0; i < 4; i++) begin
         r = $random(seed);
         txData = r[0];
         treeClock = ~treeClock;
         check_all();
      end
      finish_test();
   end
endmodule // programmable_pin_io_logic_tb
